// ### pfr_pkg.sv
// Purpose: shared constants and types for the program flash read port
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: instruction cycle is a fixed number of system clocks
package pfr_pkg;

  // Register byte offsets
  localparam logic [7:0] PFR_OFS_CTRL = 8'h00;
  localparam logic [7:0] PFR_OFS_STROBE = 8'h04;
  localparam logic [7:0] PFR_OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] PFR_OFS_ADDR_HI = 8'h0c;
  localparam logic [7:0] PFR_OFS_DATA_LO = 8'h10;
  localparam logic [7:0] PFR_OFS_DATA_HI = 8'h14;

  // Control register fields
  localparam int PFR_CTRL_RD_BIT = 0;
  localparam int PFR_CTRL_WR_BIT = 1;
  localparam int PFR_CTRL_WRITE_ENABLE_BIT_BIT = 2;

  // Implemented widths
  localparam int PFR_ADDR_LO_W = 8;
  localparam int PFR_ADDR_HI_W = 3;
  localparam int PFR_DATA_LO_W = 8;
  localparam int PFR_DATA_HI_W = 6;
  localparam int PFR_ADDR_W = PFR_ADDR_LO_W + PFR_ADDR_HI_W;
  localparam int PFR_WORD_W = PFR_DATA_LO_W + PFR_DATA_HI_W;

  // Reset values
  localparam logic [2:0] PFR_CTRL_RST = 3'h0;
  localparam logic [7:0] PFR_ADDR_LO_RST = 8'h00;
  localparam logic [2:0] PFR_ADDR_HI_RST = 3'h0;
  localparam logic [7:0] PFR_DATA_LO_RST = 8'h00;
  localparam logic [5:0] PFR_DATA_HI_RST = 6'h00;

  // System clocks per instruction cycle
  localparam int PFR_INSTR_DIV = 4;

  // Register selector
  typedef enum logic [2:0] {
    PFR_SEL_CTRL,
    PFR_SEL_STROBE,
    PFR_SEL_ADDR_LO,
    PFR_SEL_ADDR_HI,
    PFR_SEL_DATA_LO,
    PFR_SEL_DATA_HI,
    PFR_SEL_NONE
  } pfr_sel_t;

  // Request toward the flash array
  typedef struct packed {
    logic rd;
    logic [PFR_ADDR_W-1:0] addr;
  } pfr_flash_req_t;

  // Control register contents
  typedef struct packed {
    logic write_enable_bit;
    logic wr;
    logic rd;
  } pfr_ctrl_t;

endpackage

// ### pfr_cycle_div.sv
// Purpose: instruction cycle enable from the system clock
// Assumes: one clock, synchronous reset
// Notes: tick is high in the last clock of every instruction cycle
`timescale 1ns/1ps
module pfr_cycle_div
  import pfr_pkg::*;
#(
  parameter int DIV = PFR_INSTR_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Cycle boundary pulse
  output logic tick
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Count clocks within one instruction cycle
  always_comb begin
    if (cnt_q == 8'(DIV - 1)) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == 8'(DIV - 1));

  chk_tick_spacing: assert property (@(posedge clk) disable iff (srst)
    tick |=> !tick) else $error("instruction tick repeated in adjacent clocks");

endmodule

// ### pfr_fetch_seq.sv
// Purpose: sequence one program word fetch over two instruction cycles
// Assumes: tick marks the end of each instruction cycle
// Notes: the first cycle runs the next instruction, the second is stolen
`timescale 1ns/1ps
module pfr_fetch_seq
  import pfr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Cycle boundary and start request
  input wire logic tick,
  input wire logic start,
  // Sequencer state
  output logic access,
  output logic done
);

  typedef enum logic [1:0] {
    S_IDLE,
    S_FIRST,
    S_ACCESS
  } pfr_seq_state_t;

  pfr_seq_state_t state_q;
  pfr_seq_state_t state_d;

  // Next state: wait until the next tick, then access for one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (start) begin
          state_d = S_FIRST;
        end
      end
      S_FIRST: begin
        if (tick) begin
          state_d = S_ACCESS;
        end
      end
      S_ACCESS: begin
        if (tick) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Access spans the whole second instruction cycle
  assign access = (state_q == S_ACCESS);
  assign done = access && tick;

  chk_first_then_access: assert property (@(posedge clk) disable iff (srst)
    (state_q == S_FIRST) && tick |=> access) else $error("access did not follow first cycle");
  chk_access_holds: assert property (@(posedge clk) disable iff (srst)
    access && !tick |=> access) else $error("access ended before cycle boundary");
  chk_no_early_access: assert property (@(posedge clk) disable iff (srst)
    (state_q == S_IDLE) && start |=> !access) else $error("access began in first cycle");

endmodule

// ### pfr_port.sv
// Purpose: APB register front end and read path of the program flash
// Assumes: flash answers combinationally on FLASH_DATA for FLASH_REQ.addr
// Notes: zero wait state APB slave; write and erase sequencing not built
`timescale 1ns/1ps
module pfr_port
  import pfr_pkg::*;
#(
  parameter int INSTR_DIV = PFR_INSTR_DIV
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Flash array read port
  output pfr_flash_req_t FLASH_REQ,
  input wire logic [PFR_WORD_W-1:0] FLASH_DATA,
  // Core side status
  output logic CYCLE_TICK,
  output logic DISCARD_INSTR,
  output logic SEQ_STROBE
);

  // Map a byte address to a register
  function automatic pfr_sel_t decode(input logic [7:0] addr);
    case (addr)
      PFR_OFS_CTRL: decode = PFR_SEL_CTRL;
      PFR_OFS_STROBE: decode = PFR_SEL_STROBE;
      PFR_OFS_ADDR_LO: decode = PFR_SEL_ADDR_LO;
      PFR_OFS_ADDR_HI: decode = PFR_SEL_ADDR_HI;
      PFR_OFS_DATA_LO: decode = PFR_SEL_DATA_LO;
      PFR_OFS_DATA_HI: decode = PFR_SEL_DATA_HI;
      default: decode = PFR_SEL_NONE;
    endcase
  endfunction

  pfr_ctrl_t ctrl_q;
  pfr_ctrl_t ctrl_d;
  logic [PFR_ADDR_LO_W-1:0] addr_lo_q;
  logic [PFR_ADDR_LO_W-1:0] addr_lo_d;
  logic [PFR_ADDR_HI_W-1:0] addr_hi_q;
  logic [PFR_ADDR_HI_W-1:0] addr_hi_d;
  logic [PFR_DATA_LO_W-1:0] data_lo_q;
  logic [PFR_DATA_LO_W-1:0] data_lo_d;
  logic [PFR_DATA_HI_W-1:0] data_hi_q;
  logic [PFR_DATA_HI_W-1:0] data_hi_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic strobe_q;
  logic strobe_d;
  logic tick;
  logic access;
  logic done;
  logic start;
  logic wr_acc;
  logic setup_rd;
  pfr_sel_t wsel;
  pfr_sel_t rsel;

  // Instruction cycle enable
  pfr_cycle_div #(
    .DIV(INSTR_DIV)
  ) u_div (
    .clk(CLK),
    .srst(SRST),
    .tick(tick)
  );

  // Fetch sequencer
  pfr_fetch_seq u_seq (
    .clk(CLK),
    .srst(SRST),
    .tick(tick),
    .start(start),
    .access(access),
    .done(done)
  );

  // Bus phase decode
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign wsel = decode(PADDR);
  assign rsel = decode(PADDR);

  // A fetch starts when software raises the read bit while idle
  assign start = wr_acc && (wsel == PFR_SEL_CTRL) && PWDATA[PFR_CTRL_RD_BIT] && !ctrl_q.rd;

  // Next values of control and address registers
  always_comb begin
    ctrl_d = ctrl_q;
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    if (wr_acc) begin
      case (wsel)
        PFR_SEL_CTRL: begin
          ctrl_d.write_enable_bit = PWDATA[PFR_CTRL_WRITE_ENABLE_BIT_BIT];
          ctrl_d.wr = PWDATA[PFR_CTRL_WR_BIT];
          if (PWDATA[PFR_CTRL_RD_BIT]) begin
            ctrl_d.rd = 1'b1;
          end
        end
        PFR_SEL_ADDR_LO: begin
          addr_lo_d = PWDATA[PFR_ADDR_LO_W-1:0];
        end
        PFR_SEL_ADDR_HI: begin
          addr_hi_d = PWDATA[PFR_ADDR_HI_W-1:0];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    // Completion clears the read bit and wins over a software write
    if (done) begin
      ctrl_d.rd = 1'b0;
    end
  end

  // Next values of data holding registers
  always_comb begin
    data_lo_d = data_lo_q;
    data_hi_d = data_hi_q;
    if (wr_acc && (wsel == PFR_SEL_DATA_LO)) begin
      data_lo_d = PWDATA[PFR_DATA_LO_W-1:0];
    end
    if (wr_acc && (wsel == PFR_SEL_DATA_HI)) begin
      data_hi_d = PWDATA[PFR_DATA_HI_W-1:0];
    end
    // Fetched word is latched at the end of the access cycle
    if (done) begin
      data_lo_d = FLASH_DATA[PFR_DATA_LO_W-1:0];
      data_hi_d = FLASH_DATA[PFR_WORD_W-1:PFR_DATA_LO_W];
    end
  end

  // Read data is prepared in the setup phase
  always_comb begin
    rdata_d = rdata_q;
    if (setup_rd) begin
      case (rsel)
        PFR_SEL_CTRL: rdata_d = {29'h0, ctrl_q};
        PFR_SEL_ADDR_LO: rdata_d = {24'h0, addr_lo_q};
        PFR_SEL_ADDR_HI: rdata_d = {29'h0, addr_hi_q};
        PFR_SEL_DATA_LO: rdata_d = {24'h0, data_lo_q};
        PFR_SEL_DATA_HI: rdata_d = {26'h0, data_hi_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Sequence strobe pulses without storing data
  always_comb begin
    strobe_d = wr_acc && (wsel == PFR_SEL_STROBE);
  end

  // One reset value for every reset source
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_q <= pfr_ctrl_t'(PFR_CTRL_RST);
      addr_lo_q <= PFR_ADDR_LO_RST;
      addr_hi_q <= PFR_ADDR_HI_RST;
      data_lo_q <= PFR_DATA_LO_RST;
      data_hi_q <= PFR_DATA_HI_RST;
      rdata_q <= 32'h0;
      strobe_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      data_lo_q <= data_lo_d;
      data_hi_q <= data_hi_d;
      rdata_q <= rdata_d;
      strobe_q <= strobe_d;
    end
  end

  // Bus answer: zero wait, error on unmapped address
  assign PRDATA = rdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (wsel == PFR_SEL_NONE);

  // Flash and core side outputs
  assign FLASH_REQ.rd = access;
  assign FLASH_REQ.addr = {addr_hi_q, addr_lo_q};
  assign DISCARD_INSTR = access;
  assign CYCLE_TICK = tick;
  assign SEQ_STROBE = strobe_q;

  chk_rd_selfclear: assert property (@(posedge CLK) disable iff (SRST)
    done |=> !ctrl_q.rd) else $error("read bit not cleared after fetch");
  chk_data_load: assert property (@(posedge CLK) disable iff (SRST)
    done |=> {data_hi_q, data_lo_q} == $past(FLASH_DATA)) else $error("fetched word not loaded");
  chk_data_hold: assert property (@(posedge CLK) disable iff (SRST)
    !done && !(wr_acc && (wsel == PFR_SEL_DATA_LO || wsel == PFR_SEL_DATA_HI))
    |=> $stable({data_hi_q, data_lo_q})) else $error("data registers changed without cause");
  chk_unimpl_zero: assert property (@(posedge CLK) disable iff (SRST)
    setup_rd && (rsel == PFR_SEL_ADDR_HI || rsel == PFR_SEL_CTRL)
    |=> PRDATA[31:3] == 29'h0) else $error("unimplemented bits read nonzero");
  chk_strobe_empty: assert property (@(posedge CLK) disable iff (SRST)
    setup_rd && (rsel == PFR_SEL_STROBE) |=> PRDATA == 32'h0) else $error("strobe location returned data");
  chk_reset_values: assert property (@(posedge CLK)
    $past(SRST) |-> (ctrl_q == 3'h0) && (addr_lo_q == 8'h00) && (addr_hi_q == 3'h0)
    && (data_lo_q == 8'h00) && (data_hi_q == 6'h00)) else $error("register not zero after reset");
  chk_rd_pending: assert property (@(posedge CLK) disable iff (SRST)
    access |-> ctrl_q.rd) else $error("access without pending read bit");

endmodule

// ### pfr_flash_model.sv
// Purpose: behavioural flash array behind the read port
// Assumes: word is a fixed function of the address
// Notes: outside a stolen cycle the data lines toggle every clock
`timescale 1ns/1ps
module pfr_flash_model
  import pfr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Array port
  input wire pfr_flash_req_t req,
  output logic [PFR_WORD_W-1:0] data
);
  logic [PFR_WORD_W-1:0] junk_q;
  // Garbage pattern while the array is not being read
  always @(posedge clk) begin
    junk_q <= ~junk_q;
  end
  initial junk_q = 14'h0f0f;
  // Stored word only while the read is requested
  assign data = req.rd ? ({req.addr[2:0], req.addr} ^ 14'h1555) : junk_q;
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the flash read port
// Assumes: zero wait APB slave, four clocks per instruction cycle
// Notes: register tests and fetches driven through APB tasks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
  import pfr_pkg::*;
;
  logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic PREADY, PSLVERR, CYCLE_TICK, DISCARD_INSTR, SEQ_STROBE, last_err, prev_rd, prev_tick;
  pfr_flash_req_t FLASH_REQ;
  logic [PFR_WORD_W-1:0] FLASH_DATA;
  logic [10:0] exp_addr;
  int n_errors = 0, cmp_count = 0, hi_cnt = 0, cyc = 0;

  pfr_port pfr_port_inst (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FLASH_REQ(FLASH_REQ), .FLASH_DATA(FLASH_DATA), .CYCLE_TICK(CYCLE_TICK),
    .DISCARD_INSTR(DISCARD_INSTR), .SEQ_STROBE(SEQ_STROBE));
  pfr_flash_model pfr_flash_model_inst (.clk(CLK), .req(FLASH_REQ), .data(FLASH_DATA));

  // Clock and hang guard
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  // Stolen cycle watcher
  always @(posedge CLK) begin
    if (FLASH_REQ.rd === 1'b1) begin
      hi_cnt++;
      `CHK("flash addr", exp_addr, FLASH_REQ.addr)
      `CHK("discard", 1'b1, DISCARD_INSTR)
      if (prev_rd !== 1'b1) `CHK("tick before", 1'b1, prev_tick)
    end
    prev_rd = FLASH_REQ.rd;
    prev_tick = CYCLE_TICK;
  end

  // One APB transfer, request held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    last_err = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  // Read one register and compare
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("reg read", e, r)
  endtask

  // All registers at their reset value
  task chk_rst();
    for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0);
  endtask

  // Full fetch sequence at one address
  task fetch(input logic [10:0] a);
    logic [13:0] w;
    int n;
    w = {a[2:0], a} ^ 14'h1555;
    apb(1'b1, PFR_OFS_ADDR_HI, {29'h0, a[10:8]});
    apb(1'b1, PFR_OFS_ADDR_LO, {24'h0, a[7:0]});
    exp_addr = a;
    hi_cnt = 0;
    apb(1'b1, PFR_OFS_CTRL, 32'h1);
    n = 0;
    do begin apb(1'b0, PFR_OFS_CTRL, 32'h0); n++; end while (r[0] !== 1'b0 && n < 20);
    `CHK("rd clear", 1'b0, r[0])
    `CHK("stolen len", 4, hi_cnt)
    rchk(PFR_OFS_DATA_LO, {24'h0, w[7:0]});
    rchk(PFR_OFS_DATA_HI, {26'h0, w[13:8]});
    apb(1'b1, PFR_OFS_ADDR_LO, {24'h0, ~a[7:0]});
    rchk(PFR_OFS_DATA_LO, {24'h0, w[7:0]});
  endtask

  // Verdict and end of run
  task summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge CLK);
    SRST <= 1'b0;
    chk_rst();
    // Implemented widths, reserved bits read zero
    for (int i = 2; i < 6; i++) apb(1'b1, 8'(i * 4), 32'hffffffff);
    rchk(PFR_OFS_ADDR_LO, 32'hff);
    rchk(PFR_OFS_ADDR_HI, 32'h07);
    rchk(PFR_OFS_DATA_LO, 32'hff);
    rchk(PFR_OFS_DATA_HI, 32'h3f);
    apb(1'b1, PFR_OFS_CTRL, 32'hfffffff6);
    rchk(PFR_OFS_CTRL, 32'h06);
    apb(1'b1, PFR_OFS_CTRL, 32'h0);
    apb(1'b1, PFR_OFS_STROBE, 32'hff);
    @(negedge CLK);
    `CHK("seq strobe", 1'b1, SEQ_STROBE)
    @(negedge CLK);
    `CHK("seq strobe end", 1'b0, SEQ_STROBE)
    rchk(PFR_OFS_STROBE, 32'h0);
    rchk(8'h18, 32'h0);
    `CHK("slverr", 1'b1, last_err)
    fetch(11'h5a3);
    fetch(11'h7ff);
    apb(1'b1, PFR_OFS_DATA_LO, 32'h11);
    rchk(PFR_OFS_DATA_LO, 32'h11);
    fetch(11'h000);
    // Reset in mid-run restores every register
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (8) @(posedge CLK);
    SRST <= 1'b0;
    chk_rst();
    summarize();
  end
endmodule
